// file: src/otp_bank_register_map.sv
// command decode, access checks and storage of the one-time-programmable banks
`timescale 1ns/1ps

module otp_bank_register_map
  import otp_bank_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic cmd_bank_sel,
  input wire logic [otp_bank_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [otp_bank_pkg::DATA_W-1:0] cmd_wdata,
  input wire logic factory_mode,
  input wire logic otp_blank,
  output logic rd_valid_r,
  output logic [otp_bank_pkg::DATA_W-1:0] rd_data_r,
  output logic wr_done_r,
  output logic wr_refused_r,
  output logic writes_enabled_r,
  output logic [2:0] poweron_bank_r
);
  import otp_bank_pkg::*;

  // ----------------------------------------------------------------
  // storage: not reset, the contents survive a reset like real fuses
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] mem_r [WORDS];
  logic [DATA_W-1:0] mem_nxt [WORDS];
  logic [WORDS-1:0] prog_r;
  logic [WORDS-1:0] prog_nxt;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic [2:0] bank_code;
  logic [2:0] reg_idx;
  logic is_ft;
  logic is_unlock;
  logic is_trim;
  logic unlocked;
  logic otp_cmd;
  logic wr_ok;
  logic [DATA_W-1:0] wr_value;
  logic [2:0] sel_bank;
  // views of the store for the checks below
  logic [DATA_W-1:0] cur_word;
  logic [2:0] ptr_hi;
  logic [2:0] ptr_three;

  always_comb begin
    bank_code = cmd_addr[BANK_CODE_MSB:BANK_CODE_LSB];
    reg_idx = cmd_addr[REGISTER_INDEX_MSB:0];
    is_ft = (bank_code == FINAL_TEST_BANK);
    is_unlock = is_ft && (reg_idx == OTP_WRITE_UNLOCK_FLAG_IDX);
    is_trim = is_ft && (reg_idx >= FACTORY_TRIM_WORD_1_IDX) && (reg_idx <= FACTORY_TRIM_WORD_3_IDX);
    unlocked = prog_r[0] && (mem_r[0] == UNLOCK_VALUE);
    otp_cmd = cmd_valid && cmd_bank_sel;
    cur_word = mem_r[cmd_addr];
    ptr_hi = mem_r[POWERON_BANK_POINTER_4_IDX][2:0];
    ptr_three = mem_r[POWERON_BANK_POINTER_3_IDX][2:0];
    wr_ok = 1'b0;
    if (!prog_r[cmd_addr]) begin
      if (is_unlock) begin
        wr_ok = factory_mode && (cmd_wdata == UNLOCK_VALUE);
      end else if (is_trim) begin
        wr_ok = factory_mode && unlocked;
      end else begin
        wr_ok = unlocked;
      end
    end
    // pointers keep only the bank field; the rest reads as zero
    if (is_ft && reg_idx >= POWERON_BANK_POINTER_1_IDX) begin
      wr_value = cmd_wdata & POINTER_MASK;
    end else begin
      wr_value = cmd_wdata;
    end
    // highest programmed pointer wins, lower ones are ignored
    sel_bank = NO_BANK;
    for (int i = POWERON_BANK_POINTER_1_IDX; i <= POWERON_BANK_POINTER_4_IDX; i++) begin
      if (prog_r[i]) begin
        sel_bank = mem_r[i][2:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // store next state
  // ----------------------------------------------------------------
  always_comb begin
    mem_nxt = mem_r;
    prog_nxt = prog_r;
    if (otp_blank) begin
      for (int i = 0; i < WORDS; i++) begin
        mem_nxt[i] = DATA_RESET;
      end
      prog_nxt = '0;
    end else if (otp_cmd && cmd_write && wr_ok) begin
      mem_nxt[cmd_addr] = wr_value;
      prog_nxt[cmd_addr] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    mem_r <= mem_nxt;
    prog_r <= prog_nxt;
  end

  // ----------------------------------------------------------------
  // answers and power-on selection
  // ----------------------------------------------------------------
  logic boot_r;
  logic boot_nxt;
  logic rd_valid_nxt;
  logic [DATA_W-1:0] rd_data_nxt;
  logic wr_done_nxt;
  logic wr_refused_nxt;
  logic writes_enabled_nxt;
  logic [2:0] poweron_bank_nxt;

  always_comb begin
    boot_nxt = 1'b0;
    rd_valid_nxt = otp_cmd && !cmd_write;
    rd_data_nxt = (otp_cmd && !cmd_write) ? mem_r[cmd_addr] : DATA_RESET;
    wr_done_nxt = otp_cmd && cmd_write && wr_ok && !otp_blank;
    wr_refused_nxt = otp_cmd && cmd_write && !(wr_ok && !otp_blank);
    writes_enabled_nxt = unlocked;
    poweron_bank_nxt = poweron_bank_r;
    // the pointer is taken once, in the first cycle after reset
    if (boot_r) begin
      poweron_bank_nxt = sel_bank;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      boot_r <= 1'b1;
      rd_valid_r <= 1'b0;
      rd_data_r <= DATA_RESET;
      wr_done_r <= 1'b0;
      wr_refused_r <= 1'b0;
      writes_enabled_r <= 1'b0;
      poweron_bank_r <= NO_BANK;
    end else begin
      boot_r <= boot_nxt;
      rd_valid_r <= rd_valid_nxt;
      rd_data_r <= rd_data_nxt;
      wr_done_r <= wr_done_nxt;
      wr_refused_r <= wr_refused_nxt;
      writes_enabled_r <= writes_enabled_nxt;
      poweron_bank_r <= poweron_bank_nxt;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_user_write;
    cmd_valid && cmd_bank_sel && cmd_write && !otp_blank;
  endsequence

  sequence s_read_cmd;
    cmd_valid && cmd_bank_sel && !cmd_write;
  endsequence

  // an idle cycle must leave every answer low one cycle later
  sequence s_no_cmd;
    !(cmd_valid && cmd_bank_sel);
  endsequence

  // command decode and answers
  chk_ram_ignored: assert property (cmd_valid && !cmd_bank_sel |=> !rd_valid_r && !wr_done_r && !wr_refused_r)
    else $error("command for ram answered by the store");
  chk_answer_idle: assert property (s_no_cmd |=> !rd_valid_r && !wr_done_r && !wr_refused_r)
    else $error("answer without a store command");
  chk_read_word: assert property (s_read_cmd |=> rd_valid_r && rd_data_r == $past(cur_word))
    else $error("read data does not match stored word");
  chk_data_quiet: assert property (!rd_valid_r |-> rd_data_r == DATA_RESET)
    else $error("read data shown outside a read answer");

  // write protection
  chk_lock_blocks: assert property (s_user_write ##0 (!is_unlock && !unlocked)
      |=> wr_refused_r && !wr_done_r)
    else $error("write taken while store locked");
  chk_unlock_value: assert property (s_user_write ##0 (is_unlock && cmd_wdata != UNLOCK_VALUE)
      |=> wr_refused_r && !wr_done_r)
    else $error("unlock flag took a value other than the key");
  chk_factory_only: assert property (s_user_write ##0 ((is_unlock || is_trim) && !factory_mode)
      |=> wr_refused_r ##0 mem_r[$past(cmd_addr)] == $past(cur_word))
    else $error("user write reached a factory location");
  chk_single_write: assert property (s_user_write ##0 prog_r[cmd_addr]
      |=> wr_refused_r ##0 mem_r[$past(cmd_addr)] == $past(cur_word))
    else $error("programmed location written twice");
  chk_enable_follow: assert property (wr_done_r && $past(is_unlock) |=> writes_enabled_r)
    else $error("accepted unlock write did not enable writes");

  // store contents
  chk_pointer_write: assert property (s_user_write ##0 (is_ft && reg_idx[2] && unlocked && !prog_r[cmd_addr])
      |=> wr_done_r ##0 mem_r[$past(cmd_addr)] == ($past(cmd_wdata) & POINTER_MASK))
    else $error("pointer write not stored");
  chk_user_store: assert property (s_user_write ##0 (!is_ft && unlocked && !prog_r[cmd_addr])
      |=> wr_done_r ##0 mem_r[$past(cmd_addr)] == $past(cmd_wdata))
    else $error("user bank write not stored");

  // power-on pointer selection
  chk_boot_priority: assert property (boot_r && prog_r[POWERON_BANK_POINTER_4_IDX]
      |=> poweron_bank_r == $past(ptr_hi) ##1 $stable(poweron_bank_r))
    else $error("highest pointer not chosen at power-on");
  chk_boot_fallback: assert property (boot_r && !prog_r[POWERON_BANK_POINTER_4_IDX]
      && prog_r[POWERON_BANK_POINTER_3_IDX] |=> poweron_bank_r == $past(ptr_three))
    else $error("next lower pointer not chosen at power-on");
  chk_boot_hold: assert property (!boot_r |=> $stable(poweron_bank_r))
    else $error("power-on bank moved after power-on");
endmodule : otp_bank_register_map

// file: src/otp_bank_pkg.sv
// constants for the one-time-programmable register store
package otp_bank_pkg;
  // ----------------------------------------------------------------
  // address layout of the command
  // ----------------------------------------------------------------
  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;
  localparam int WORDS = 64;
  localparam int BANK_CODE_LSB = 3;
  localparam int BANK_CODE_MSB = 5;
  localparam int REGISTER_INDEX_MSB = 2;
  localparam logic [2:0] FINAL_TEST_BANK = 3'h0;
  // ----------------------------------------------------------------
  // final-test bank register indices
  // ----------------------------------------------------------------
  localparam logic [2:0] OTP_WRITE_UNLOCK_FLAG_IDX = 3'h0;
  localparam logic [2:0] FACTORY_TRIM_WORD_1_IDX = 3'h1;
  localparam logic [2:0] FACTORY_TRIM_WORD_2_IDX = 3'h2;
  localparam logic [2:0] FACTORY_TRIM_WORD_3_IDX = 3'h3;
  localparam logic [2:0] POWERON_BANK_POINTER_1_IDX = 3'h4;
  localparam logic [2:0] POWERON_BANK_POINTER_2_IDX = 3'h5;
  localparam logic [2:0] POWERON_BANK_POINTER_3_IDX = 3'h6;
  localparam logic [2:0] POWERON_BANK_POINTER_4_IDX = 3'h7;
  // ----------------------------------------------------------------
  // user bank register indices
  // ----------------------------------------------------------------
  localparam logic [2:0] FINE_OFFSET_VALUE_IDX = 3'h0;
  localparam logic [2:0] FINE_GAIN_VALUE_IDX = 3'h1;
  localparam logic [2:0] CONFIGURATION_WORD_0_IDX = 3'h2;
  localparam logic [2:0] CONFIGURATION_WORD_1_IDX = 3'h3;
  localparam logic [2:0] CONFIGURATION_WORD_2_IDX = 3'h4;
  localparam logic [2:0] CHECKSUM_WORD_IDX = 3'h5;
  localparam logic [2:0] USER_INFO_WORD_1_IDX = 3'h6;
  localparam logic [2:0] USER_INFO_WORD_2_IDX = 3'h7;
  // ----------------------------------------------------------------
  // values
  // ----------------------------------------------------------------
  localparam logic [15:0] UNLOCK_VALUE = 16'hCC00;
  localparam logic [15:0] POINTER_MASK = 16'h0007;
  localparam logic [15:0] DATA_RESET = 16'h0000;
  localparam logic [2:0] NO_BANK = 3'h0;
endpackage : otp_bank_pkg

// file: test/otp_programmer_model.sv
// external programmer model issuing single-cycle store commands
`timescale 1ns/1ps
module otp_programmer_model
  import otp_bank_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rd_valid_r,
  input wire logic [otp_bank_pkg::DATA_W-1:0] rd_data_r,
  input wire logic wr_done_r,
  input wire logic wr_refused_r,
  output logic cmd_valid = 1'b0,
  output logic cmd_write = 1'b0,
  output logic cmd_bank_sel = 1'b0,
  output logic [otp_bank_pkg::ADDR_W-1:0] cmd_addr = 6'h00,
  output logic [otp_bank_pkg::DATA_W-1:0] cmd_wdata = 16'h0000
);
  // called at a rising edge; answer code 1 read, 2 stored, 3 refused, 0 none
  task automatic xfer(input logic w, input logic sel, input logic [5:0] a, input logic [15:0] d,
                      output logic [1:0] ans, output logic [15:0] q);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_bank_sel <= sel;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    // released lines must not keep showing the old word
    cmd_addr <= ~a;
    cmd_wdata <= ~d;
    #1;
    ans = rd_valid_r ? 2'h1 : wr_done_r ? 2'h2 : wr_refused_r ? 2'h3 : 2'h0;
    q = rd_data_r;
    @(posedge clk_sys);
  endtask : xfer
endmodule : otp_programmer_model

// file: test/test_otp_bank_register_map.sv
// self-checking bench for the one-time-programmable register map
`timescale 1ns/1ps
module test_otp_bank_register_map;
  import otp_bank_pkg::*;
  // ----------------------------------------------------------------
  // clock, reset and hookup
  // ----------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic factory_mode = 1'b0;
  logic otp_blank = 1'b0;
  logic cmd_valid, cmd_write, cmd_bank_sel, rd_valid_r, wr_done_r, wr_refused_r, writes_enabled_r;
  logic [ADDR_W-1:0] cmd_addr;
  logic [DATA_W-1:0] cmd_wdata, rd_data_r, q;
  logic [2:0] poweron_bank_r;
  logic [1:0] ans;
  int fail_count = 0;
  int checked = 0;
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  otp_bank_register_map dut_u (.clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_bank_sel(cmd_bank_sel), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .factory_mode(factory_mode),
    .otp_blank(otp_blank), .rd_valid_r(rd_valid_r), .rd_data_r(rd_data_r), .wr_done_r(wr_done_r),
    .wr_refused_r(wr_refused_r), .writes_enabled_r(writes_enabled_r), .poweron_bank_r(poweron_bank_r));
  otp_programmer_model prog_u (.clk_sys(clk_sys), .rd_valid_r(rd_valid_r), .rd_data_r(rd_data_r),
    .wr_done_r(wr_done_r), .wr_refused_r(wr_refused_r), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_bank_sel(cmd_bank_sel), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata));
  // ----------------------------------------------------------------
  // checking tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    if (fail_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic run(input logic w, input logic [5:0] a, input logic [15:0] d, input logic [1:0] ea,
                     input logic [15:0] eq);
    prog_u.xfer(w, 1'b1, a, d, ans, q);
    chk({14'h0000, ans}, {14'h0000, ea});
    chk(q, eq);
  endtask : run
  initial begin
    repeat (2000) @(posedge clk_sys);
    fail_count++;
    stop_test();
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    otp_blank <= 1'b1;
    @(posedge clk_sys);
    otp_blank <= 1'b0;
    run(1'b1, 6'h0C, 16'h1234, 2'h3, 16'h0000);
    run(1'b1, 6'h00, UNLOCK_VALUE, 2'h3, 16'h0000);
    factory_mode <= 1'b1;
    run(1'b1, 6'h00, 16'hCC01, 2'h3, 16'h0000);
    run(1'b1, 6'h01, 16'h5A5A, 2'h3, 16'h0000);
    run(1'b1, 6'h00, UNLOCK_VALUE, 2'h2, 16'h0000);
    run(1'b1, 6'h01, 16'h5A5A, 2'h2, 16'h0000);
    factory_mode <= 1'b0;
    chk({15'h0000, writes_enabled_r}, 16'h0001);
    run(1'b1, 6'h00, 16'h0000, 2'h3, 16'h0000);
    run(1'b1, 6'h02, 16'h1111, 2'h3, 16'h0000);
    run(1'b0, 6'h00, 16'h0000, 2'h1, UNLOCK_VALUE);
    run(1'b0, 6'h01, 16'h0000, 2'h1, 16'h5A5A);
    for (int b = 1; b < 8; b++) begin
      run(1'b1, {b[2:0], b[2:0]}, 16'hA000 + b[15:0], 2'h2, 16'h0000);
      run(1'b0, {b[2:0], b[2:0]}, 16'h0000, 2'h1, 16'hA000 + b[15:0]);
    end
    run(1'b0, 6'h11, 16'h0000, 2'h1, DATA_RESET);
    run(1'b1, 6'h09, 16'h0000, 2'h3, 16'h0000);
    run(1'b1, 6'h04, 16'h0003, 2'h2, 16'h0000);
    run(1'b1, 6'h06, 16'hFFF5, 2'h2, 16'h0000);
    run(1'b0, 6'h06, 16'h0000, 2'h1, 16'h0005);
    run(1'b1, 6'h04, 16'h0002, 2'h3, 16'h0000);
    prog_u.xfer(1'b1, 1'b0, 6'h05, 16'h0001, ans, q);
    chk({14'h0000, ans}, 16'h0000);
    rst <= 1'b1;
    @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk({13'h0000, poweron_bank_r}, 16'h0005);
    run(1'b0, 6'h04, 16'h0000, 2'h1, 16'h0003);
    run(1'b1, 6'h07, 16'h0002, 2'h2, 16'h0000);
    run(1'b0, 6'h07, 16'h0000, 2'h1, 16'h0002);
    chk({13'h0000, poweron_bank_r}, 16'h0005);
    rst <= 1'b1;
    @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk({13'h0000, poweron_bank_r}, 16'h0002);
    chk({15'h0000, writes_enabled_r}, 16'h0001);
    stop_test();
  end
endmodule : test_otp_bank_register_map
